// *** rtl/sutx_csi_tx.v ***
// clocked three-wire serial transmitter, three channels, with the shared port pins
// assumes a single-master register port: one access per cycle, read data one cycle later
//
// Behaviour
// - input buffer select bit: 0 normal buffer, 1 TTL buffer; resets to zero
// - output mode bit: 0 push-pull, 1 open-drain
// - direction bit 0 drives the pin, 1 makes it input; resets to all ones
// - clearing unit enable bit 2 halts every channel
// - unit disabled: serial register writes ignored, reads give defaults; port regs exempt
// - channel enable status is read-only, cleared only by stop trigger
// - stop trigger bit self-clears once its enable status bit is zero
// - clock level bit writable only while the channel is stopped
// - channels 0 to 2 only; channel 3 has no function
// - frame length selectable as 7 or 8 bits
// - master generates clock and shifts data out; no error flag
// - interrupt on transfer end, or on buffer empty in continuous mode
// - clock rate from system clock over 4 down to over 2*2^11*128
// - data phase 1 puts data out half a clock before the clock starts
// - clock phase bit: 0 forward, 1 reversed clock
// - stopping keeps pin levels; level register reprogrammed before resuming
// - resume: outputs off, set levels, outputs on, start trigger, write data
// - level bit n drives data pin n, bit n+8 drives clock pin n
// - data level bit ignores writes while serial output is enabled
`timescale 1ns/1ns
`include "sutx_map.vh"
module sutx_csi_tx (
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  input  wire [19:0] reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  output reg  [2:0]  tx_buf_ready_out,
  output wire        serial0_irq_out,
  output wire        serial1_irq_out,
  output wire        serial2_irq_out,
  output reg  [7:0]  port3_pin_out,
  output reg  [7:0]  port3_pin_oe_n_out,
  output reg  [7:0]  port3_ttl_sel_out,
  output reg  [7:0]  port7_pin_out,
  output reg  [7:0]  port7_pin_oe_n_out,
  output reg  [7:0]  port7_ttl_sel_out
);
  reg  [7:0]  peripheral_enable;
  reg  [7:0]  port3_input_buffer_select;
  reg  [7:0]  port7_input_buffer_select;
  reg  [7:0]  port3_output_mode_select;
  reg  [7:0]  port7_output_mode_select;
  reg  [7:0]  port3_direction;
  reg  [7:0]  port7_direction;
  reg  [7:0]  port3_latch;
  reg  [7:0]  port7_latch;
  reg  [2:0]  channel_enable_status;
  reg  [2:0]  channel_stop_trigger;
  reg  [2:0]  output_enable_reg;
  reg  [2:0]  data_out_level;
  reg  [2:0]  clock_out_level;
  reg  [3:0]  prescaler_select;
  reg  [6:0]  divr [0:2];
  reg  [4:0]  mode [0:2];
  reg  [15:0] next_rdata;
  reg  [7:0]  next_p3;
  reg  [7:0]  next_p7;
  integer     k;

  wire        unit_en = peripheral_enable[`SUTX_PER_UNIT];
  wire        ser_wr  = reg_wr_in & unit_en;
  wire [2:0]  push;
  wire [2:0]  fifo_in_rdy;
  wire [2:0]  fifo_valid;
  wire [2:0]  pop;
  wire [2:0]  fire;
  wire [2:0]  eng_so_we;
  wire [2:0]  eng_so_v;
  wire [2:0]  eng_ck_we;
  wire [2:0]  eng_ck_v;
  wire [7:0]  fdata  [0:2];
  wire [4:0]  flevel [0:2];

  function [19:0] ch_addr;
    input [19:0] base;
    input [1:0]  idx;
    begin
      ch_addr = base + {17'h00000, idx, 1'b0};
    end
  endfunction

  assign serial0_irq_out = fire[0];
  assign serial1_irq_out = fire[1];
  assign serial2_irq_out = fire[2];

  // one engine per channel; a fourth channel does not exist here
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      localparam [1:0] CH = g;
      reg  [7:0] sh;
      reg  [4:0] half;
      reg        run;
      reg        so_we;
      reg        so_v;
      reg        ck_we;
      reg        ck_v;
      reg        irq;
      wire       tick;
      wire [4:0] md   = mode[g];
      wire [7:0] fd   = fdata[g];
      wire [4:0] lvl  = flevel[g];
      wire       cont = md[`SUTX_MODE_CONT];
      wire       lsbf = md[`SUTX_MODE_LSBF];
      wire       len8 = md[`SUTX_MODE_LEN8];
      wire       dap  = md[`SUTX_MODE_DAP];
      wire       ckp  = md[`SUTX_MODE_CKP];
      wire       go   = channel_enable_status[g] & unit_en;
      wire       start = go & ~run & fifo_valid[g];
      wire [4:0] last_half = len8 ? `SUTX_LAST_HALF8 : `SUTX_LAST_HALF7;
      // a 7-bit msb-first frame is pre-shifted so bit 7 always holds the first bit
      wire [7:0] ld  = (~lsbf & ~len8) ? {fd[6:0], 1'b0} : fd;
      wire       cur = lsbf ? sh[0] : sh[7];
      wire       nxt = lsbf ? sh[1] : sh[6];

      assign push[g]      = ser_wr & (reg_addr_in == ch_addr(`SUTX_A_DATA0, CH));
      assign pop[g]       = start;
      assign fire[g]      = irq;
      assign eng_so_we[g] = so_we;
      assign eng_so_v[g]  = so_v;
      assign eng_ck_we[g] = ck_we;
      assign eng_ck_v[g]  = ck_v;

      always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sh    <= 8'h00;
          half  <= 5'h00;
          run   <= 1'b0;
          so_we <= 1'b0;
          so_v  <= 1'b0;
          ck_we <= 1'b0;
          ck_v  <= 1'b0;
          irq   <= 1'b0;
        end else begin
          so_we <= 1'b0;
          ck_we <= 1'b0;
          irq   <= 1'b0;
          if (!go) begin
            run <= 1'b0;
          end else if (start) begin
            sh    <= ld;
            half  <= 5'h00;
            run   <= 1'b1;
            ck_we <= 1'b1;
            ck_v  <= ~ckp;
            if (dap) begin
              so_we <= 1'b1;
              so_v  <= lsbf ? ld[0] : ld[7];
            end
            if (cont && lvl == 5'h01) begin
              irq <= 1'b1;
            end
          end else if (run && tick) begin
            half  <= half + 5'h01;
            ck_we <= 1'b1;
            ck_v  <= half[0] ? ~ckp : ckp;
            if (!half[0]) begin
              if (!dap) begin
                so_we <= 1'b1;
                so_v  <= cur;
              end
            end else begin
              sh <= lsbf ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
              if (dap && half != last_half) begin
                so_we <= 1'b1;
                so_v  <= nxt;
              end
            end
            if (half == last_half) begin
              run <= 1'b0;
              if (!cont) begin
                irq <= 1'b1;
              end
            end
          end
        end
      end

      // a zero divider would exceed the fastest rate, so it runs as one
      sutx_baud u_baud (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .run_in     (run),
        .shift_in   (prescaler_select),
        .div_in     ((divr[g] == 7'h00) ? 7'h01 : divr[g]),
        .tick_out   (tick)
      );

      sutx_fifo #(
        .WIDTH (8),
        .DEPTH (16),
        .AW    (4)
      ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (push[g]),
        .in_ready_out  (fifo_in_rdy[g]),
        .in_data_in    (reg_wdata_in[7:0]),
        .out_valid_out (fifo_valid[g]),
        .out_ready_in  (pop[g]),
        .out_data_out  (fdata[g]),
        .level_out     (flevel[g])
      );
    end
  endgenerate

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      peripheral_enable         <= 8'h00;
      port3_input_buffer_select <= `SUTX_RST_SEL;
      port7_input_buffer_select <= `SUTX_RST_SEL;
      port3_output_mode_select  <= `SUTX_RST_SEL;
      port7_output_mode_select  <= `SUTX_RST_SEL;
      port3_direction           <= `SUTX_RST_DIR;
      port7_direction           <= `SUTX_RST_DIR;
      port3_latch               <= `SUTX_RST_LATCH;
      port7_latch               <= `SUTX_RST_LATCH;
      channel_enable_status     <= 3'h0;
      channel_stop_trigger      <= 3'h0;
      output_enable_reg         <= 3'h0;
      data_out_level            <= `SUTX_RST_LVL;
      clock_out_level           <= `SUTX_RST_LVL;
      prescaler_select          <= 4'h0;
      for (k = 0; k < 3; k = k + 1) begin
        divr[k] <= `SUTX_RST_DIV;
        mode[k] <= `SUTX_RST_MODE;
      end
    end else begin
      // port configuration stays writable whatever the unit enable says
      if (reg_wr_in) begin
        case (reg_addr_in)
          `SUTX_A_PER_EN:   peripheral_enable         <= reg_wdata_in[7:0];
          `SUTX_A_P3_IBUF:  port3_input_buffer_select <= reg_wdata_in[7:0];
          `SUTX_A_P7_IBUF:  port7_input_buffer_select <= reg_wdata_in[7:0];
          `SUTX_A_P3_OMODE: port3_output_mode_select  <= reg_wdata_in[7:0];
          `SUTX_A_P7_OMODE: port7_output_mode_select  <= reg_wdata_in[7:0];
          `SUTX_A_P3_DIR:   port3_direction           <= reg_wdata_in[7:0];
          `SUTX_A_P7_DIR:   port7_direction           <= reg_wdata_in[7:0];
          `SUTX_A_P3_LATCH: port3_latch               <= reg_wdata_in[7:0];
          `SUTX_A_P7_LATCH: port7_latch               <= reg_wdata_in[7:0];
          default: ;
        endcase
      end
      channel_stop_trigger  <= channel_stop_trigger & channel_enable_status;
      channel_enable_status <= channel_enable_status & ~channel_stop_trigger;
      for (k = 0; k < 3; k = k + 1) begin
        if (eng_so_we[k] && output_enable_reg[k]) begin
          data_out_level[k] <= eng_so_v[k];
        end
        if (eng_ck_we[k]) begin
          clock_out_level[k] <= eng_ck_v[k];
        end
      end
      if (ser_wr) begin
        case (reg_addr_in)
          `SUTX_A_START: channel_enable_status <= (channel_enable_status
                                                   & ~channel_stop_trigger)
                                                  | reg_wdata_in[2:0];
          `SUTX_A_STOP:  channel_stop_trigger  <= (channel_stop_trigger
                                                   & channel_enable_status)
                                                  | reg_wdata_in[2:0];
          `SUTX_A_OUT_EN: output_enable_reg <= reg_wdata_in[2:0];
          `SUTX_A_PRESC:  prescaler_select  <= (reg_wdata_in[3:0] > `SUTX_PRESC_MAX) ?
                                               `SUTX_PRESC_MAX : reg_wdata_in[3:0];
          default: ;
        endcase
        for (k = 0; k < 3; k = k + 1) begin
          if (reg_addr_in == `SUTX_A_OUT_LVL) begin
            if (!output_enable_reg[k]) begin
              data_out_level[k] <= reg_wdata_in[k];
            end
            if (!channel_enable_status[k]) begin
              clock_out_level[k] <= reg_wdata_in[k+8];
            end
          end
          if (reg_addr_in == ch_addr(`SUTX_A_DATA0, k[1:0])) begin
            divr[k] <= reg_wdata_in[15:9];
          end
          if (reg_addr_in == ch_addr(`SUTX_A_MODE0, k[1:0])) begin
            mode[k] <= reg_wdata_in[4:0];
          end
        end
      end
    end
  end

  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr_in)
      `SUTX_A_PER_EN:   next_rdata[7:0] = peripheral_enable;
      `SUTX_A_P3_IBUF:  next_rdata[7:0] = port3_input_buffer_select;
      `SUTX_A_P7_IBUF:  next_rdata[7:0] = port7_input_buffer_select;
      `SUTX_A_P3_OMODE: next_rdata[7:0] = port3_output_mode_select;
      `SUTX_A_P7_OMODE: next_rdata[7:0] = port7_output_mode_select;
      `SUTX_A_P3_DIR:   next_rdata[7:0] = port3_direction;
      `SUTX_A_P7_DIR:   next_rdata[7:0] = port7_direction;
      `SUTX_A_P3_LATCH: next_rdata[7:0] = port3_latch;
      `SUTX_A_P7_LATCH: next_rdata[7:0] = port7_latch;
      `SUTX_A_CH_EN:    next_rdata[2:0] = channel_enable_status;
      `SUTX_A_OUT_EN:   next_rdata[2:0] = output_enable_reg;
      `SUTX_A_PRESC:    next_rdata[3:0] = prescaler_select;
      `SUTX_A_OUT_LVL:  next_rdata = unit_en ?
                          {4'h0, 1'b1, clock_out_level, 4'h0, 1'b1, data_out_level} :
                          {4'h0, 1'b1, `SUTX_RST_LVL, 4'h0, 1'b1, `SUTX_RST_LVL};
      default: ;
    endcase
    for (k = 0; k < 3; k = k + 1) begin
      if (reg_addr_in == ch_addr(`SUTX_A_DATA0, k[1:0])) begin
        next_rdata = {unit_en ? divr[k] : `SUTX_RST_DIV, 9'h000};
      end
      if (reg_addr_in == ch_addr(`SUTX_A_MODE0, k[1:0])) begin
        next_rdata = {11'h000, unit_en ? mode[k] : `SUTX_RST_MODE};
      end
    end
    if (!unit_en && (reg_addr_in == `SUTX_A_CH_EN || reg_addr_in == `SUTX_A_OUT_EN
                     || reg_addr_in == `SUTX_A_PRESC)) begin
      next_rdata = 16'h0000;
    end
  end

  // serial pins are the port latch anded with the level bit, so both must be 1
  always @* begin
    next_p3    = port3_latch;
    next_p7    = port7_latch;
    next_p7[3] = port7_latch[3] & data_out_level[0];
    next_p7[5] = port7_latch[5] & clock_out_level[0];
    next_p7[0] = port7_latch[0] & data_out_level[1];
    next_p7[2] = port7_latch[2] & clock_out_level[1];
    next_p3[0] = port3_latch[0] & data_out_level[2];
    next_p3[2] = port3_latch[2] & clock_out_level[2];
  end

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out      <= 16'h0000;
      tx_buf_ready_out   <= 3'h0;
      port3_pin_out      <= 8'h00;
      port7_pin_out      <= 8'h00;
      port3_pin_oe_n_out <= 8'hFF;
      port7_pin_oe_n_out <= 8'hFF;
      port3_ttl_sel_out  <= 8'h00;
      port7_ttl_sel_out  <= 8'h00;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
      // stale by one cycle, so it drops while one place is still free
      for (k = 0; k < 3; k = k + 1) begin
        tx_buf_ready_out[k] <= fifo_in_rdy[k] & (flevel[k] < 5'h0F) & unit_en;
      end
      port3_pin_out      <= next_p3;
      port7_pin_out      <= next_p7;
      // open drain releases the pin for a 1 instead of driving it
      port3_pin_oe_n_out <= port3_direction | (port3_output_mode_select & next_p3);
      port7_pin_oe_n_out <= port7_direction | (port7_output_mode_select & next_p7);
      port3_ttl_sel_out  <= port3_input_buffer_select;
      port7_ttl_sel_out  <= port7_input_buffer_select;
    end
  end
endmodule // sutx_csi_tx

// *** rtl/sutx_map.vh ***
// register addresses, field positions and reset values of the serial transmit block
// assumes the includer runs a 20-bit byte-addressed register port with 16-bit data
`ifndef SUTX_MAP_VH
`define SUTX_MAP_VH

`define SUTX_A_P3_IBUF   20'hF0043
`define SUTX_A_P7_IBUF   20'hF0047
`define SUTX_A_P3_OMODE  20'hF0053
`define SUTX_A_P7_OMODE  20'hF0057
`define SUTX_A_P3_DIR    20'hFFF23
`define SUTX_A_P7_DIR    20'hFFF27
`define SUTX_A_P3_LATCH  20'hFFF03
`define SUTX_A_P7_LATCH  20'hFFF07
`define SUTX_A_PER_EN    20'hF00F0
`define SUTX_A_DATA0     20'hF0110
`define SUTX_A_MODE0     20'hF0118
`define SUTX_A_CH_EN     20'hF0120
`define SUTX_A_START     20'hF0122
`define SUTX_A_STOP      20'hF0124
`define SUTX_A_PRESC     20'hF0126
`define SUTX_A_OUT_LVL   20'hF0128
`define SUTX_A_OUT_EN    20'hF012A

`define SUTX_RST_SEL     8'h00
`define SUTX_RST_DIR     8'hFF
`define SUTX_RST_LATCH   8'h00
`define SUTX_RST_MODE    5'h04
`define SUTX_RST_DIV     7'h01
`define SUTX_RST_LVL     3'h7

`define SUTX_PER_UNIT    2
`define SUTX_MODE_CONT   0
`define SUTX_MODE_LSBF   1
`define SUTX_MODE_LEN8   2
`define SUTX_MODE_DAP    3
`define SUTX_MODE_CKP    4
`define SUTX_PRESC_MAX   4'hB
`define SUTX_LAST_HALF8  5'h0F
`define SUTX_LAST_HALF7  5'h0D

`endif

// *** rtl/sutx_fifo.v ***
// transmit byte buffer with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
module sutx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys_in,
  input  wire             reset_n_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0]      level_out
);
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_push = in_valid_in & in_ready_out;
  wire            do_pop  = out_ready_in & out_valid_out;

  assign in_ready_out  = (count != FULL_CNT);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr];
  assign level_out     = count;

  always @(posedge clk_sys_in) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sutx_fifo

// *** rtl/sutx_baud.v ***
// half-period tick generator: prescaler of 2^shift then a divide by div+1
// assumes run_in falls between frames so each frame starts from a clean count
`timescale 1ns/1ns
module sutx_baud (
  input  wire       clk_sys_in,
  input  wire       reset_n_in,
  input  wire       run_in,
  input  wire [3:0] shift_in,
  input  wire [6:0] div_in,
  output reg        tick_out
);
  reg  [10:0] pre;
  reg  [6:0]  cnt;
  wire [10:0] pre_lim = (11'h001 << shift_in) - 11'h001;

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre      <= 11'h000;
      cnt      <= 7'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      pre      <= 11'h000;
      cnt      <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (pre == pre_lim) begin
        pre <= 11'h000;
        if (cnt == div_in) begin
          cnt      <= 7'h00;
          tick_out <= 1'b1;
        end else begin
          cnt <= cnt + 7'h01;
        end
      end else begin
        pre <= pre + 11'h001;
      end
    end
  end
endmodule // sutx_baud

// *** verif/sutx_csi_tx_properties.sv ***
// port-level assertions for the serial transmit block
// assumes it is bound to sutx_csi_tx and sees nothing but its ports
`timescale 1ns/1ns
`include "sutx_map.vh"
module sutx_csi_tx_properties (
  input wire        clk_sys_in,
  input wire        reset_n_in,
  input wire [19:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire [2:0]  tx_buf_ready_out,
  input wire        serial0_irq_out,
  input wire        serial1_irq_out,
  input wire        serial2_irq_out,
  input wire [7:0]  port3_pin_out,
  input wire [7:0]  port3_pin_oe_n_out,
  input wire [7:0]  port3_ttl_sel_out,
  input wire [7:0]  port7_pin_out,
  input wire [7:0]  port7_pin_oe_n_out,
  input wire [7:0]  port7_ttl_sel_out
);
  reg        unit_en;
  reg  [2:0] hist;
  reg  [7:0] dir7;
  reg  [7:0] om7;
  wire [2:0] irq = {serial2_irq_out, serial1_irq_out, serial0_irq_out};
  wire [2:0] ck  = {port3_pin_out[2], port7_pin_out[2], port7_pin_out[5]};
  // shadow copies rebuilt from the write strobes, since the checker cannot see inside
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unit_en <= 1'b0;
      hist    <= 3'h0;
      dir7    <= 8'hFF;
      om7     <= 8'h00;
    end else begin
      hist <= {hist[1:0], unit_en};
      if (reg_wr_in && reg_addr_in == `SUTX_A_PER_EN) unit_en <= reg_wdata_in[`SUTX_PER_UNIT];
      if (reg_wr_in && reg_addr_in == `SUTX_A_P7_DIR) dir7 <= reg_wdata_in[7:0];
      if (reg_wr_in && reg_addr_in == `SUTX_A_P7_OMODE) om7 <= reg_wdata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_stop0;
    reg_wr_in && reg_addr_in == `SUTX_A_STOP && reg_wdata_in[0];
  endsequence
  sequence s_quiet6;
    (!reg_wr_in) [*6];
  endsequence
  property p_irq_pulse;
    irq != 3'h0 |=> (irq & $past(irq)) == 3'h0;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
  property p_ready_off;
    !unit_en && hist == 3'h0 |-> tx_buf_ready_out == 3'h0;
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready while unit off");
  property p_ck_frozen;
    !unit_en && hist == 3'h0 && !reg_wr_in |=> $stable(ck) && irq == 3'h0;
  endproperty
  a_ck_frozen: assert property (p_ck_frozen) else $error("activity while unit off");
  property p_ck_rate;
    $changed(ck[0]) && !reg_wr_in |=> $stable(ck[0]);
  endproperty
  a_ck_rate: assert property (p_ck_rate) else $error("clock faster than fclk/4");
  property p_dir_oe;
    (dir7 & $past(dir7) & ~port7_pin_oe_n_out) == 8'h00;
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("input pin driven");
  property p_od;
    (om7 & $past(om7) & port7_pin_out & ~port7_pin_oe_n_out) == 8'h00;
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin drives high");
  property p_ttl_quiet;
    !$past(reg_wr_in) && !$past(reg_wr_in, 2) |-> $stable({port3_ttl_sel_out, port7_ttl_sel_out});
  endproperty
  a_ttl_quiet: assert property (p_ttl_quiet) else $error("buffer select moved");
  property p_stop_hold;
    s_stop0 ##1 s_quiet6 |-> $stable(port7_pin_out[5]) && $stable(port7_pin_out[3]);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("pins moved after stop");
endmodule // sutx_csi_tx_properties

bind sutx_csi_tx sutx_csi_tx_properties i_props (.*);

// *** verif/sutx_rx_model.sv ***
// receiving device on one channel's clock and data wires
// assumes undriven wires idle high through a pull-up
`timescale 1ns/1ns
module sutx_rx_model (
  input  wire       ck_in,
  input  wire       dat_in,
  input  wire       ckp_in,
  input  wire       dap_in,
  input  wire       clr_in,
  output reg  [7:0] bits_out,
  output reg  [7:0] count_out
);
  // take data on the edge opposite the launching one, so it is settled
  always @(posedge ck_in or negedge ck_in or posedge clr_in) begin
    if (clr_in) begin
      bits_out  <= 8'h00;
      count_out <= 8'h00;
    end else if (ck_in == (ckp_in ^ ~dap_in)) begin
      bits_out  <= {bits_out[6:0], dat_in};
      count_out <= count_out + 8'h01;
    end
  end
endmodule // sutx_rx_model

// *** verif/sutx_csi_tx_tb.sv ***
// self-checking bench: register port stimulus, receivers on all three channels
// assumes the register map header and a 10 MHz system clock
`timescale 1ns/1ns
`include "sutx_map.vh"
module sutx_csi_tx_tb;
  reg         clk_sys_in;
  reg         reset_n_in;
  reg  [19:0] reg_addr_in;
  reg  [15:0] reg_wdata_in;
  reg         reg_wr_in;
  reg         reg_rd_in;
  wire [15:0] reg_rdata_out;
  wire [2:0]  rdy;
  wire [2:0]  irq;
  wire [7:0]  p3, p3_oe_n, ttl3, p7, p7_oe_n, ttl7;
  wire [7:0]  w3 = p3 | p3_oe_n;
  wire [7:0]  w7 = p7 | p7_oe_n;
  wire [23:0] bits, cnt;
  reg  [2:0]  ckp, dap;
  reg         clr;
  reg  [7:0]  b;
  reg  [4:0]  md;
  reg  [6:0]  dv;
  reg  [1:0]  ch;
  integer     bad_count, check_count, seed, i, k;
  sutx_csi_tx i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tx_buf_ready_out(rdy),
    .serial0_irq_out(irq[0]), .serial1_irq_out(irq[1]), .serial2_irq_out(irq[2]),
    .port3_pin_out(p3), .port3_pin_oe_n_out(p3_oe_n), .port3_ttl_sel_out(ttl3),
    .port7_pin_out(p7), .port7_pin_oe_n_out(p7_oe_n), .port7_ttl_sel_out(ttl7));
  sutx_rx_model i_rx [2:0] (.ck_in({w3[2], w7[2], w7[5]}), .dat_in({w3[0], w7[0], w7[3]}),
    .ckp_in(ckp), .dap_in(dap), .clr_in({3{clr}}), .bits_out(bits), .count_out(cnt));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task limit(input ok);
    if (!ok) begin
      bad_count = bad_count + 1;
      $display("[FAIL] wait expected done seen timeout");
      end_of_test;
    end
  endtask
  task wr(input [19:0] a, input [15:0] d);
    begin
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [19:0] a, input [15:0] exp, input [63:0] nm);
    begin
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(posedge clk_sys_in);
      #1 chk(nm, exp, reg_rdata_out);
    end
  endtask
  // arrival order of the frame bits, first bit ending up highest
  function [7:0] expect_bits(input [7:0] d, input lsbf, input len8);
    integer j;
    begin
      expect_bits = 8'h00;
      for (j = 0; j < (len8 ? 8 : 7); j = j + 1)
        expect_bits = {expect_bits[6:0], lsbf ? d[j] : d[(len8 ? 7 : 6) - j]};
    end
  endfunction
  initial begin
    seed = 32'h6F84C06B;
    bad_count = 0;
    check_count = 0;
    reset_n_in = 1'b0;
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = 38'h0;
    {ckp, dap, clr} = 7'h01;
    repeat (12) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    chk("oe7", 16'h00FF, {8'h00, p7_oe_n});
    rd(`SUTX_A_P7_DIR, 16'h00FF, "dir7");
    rd(`SUTX_A_P3_DIR, 16'h00FF, "dir3");
    rd(`SUTX_A_P3_IBUF, 16'h0000, "ibuf3");
    rd(`SUTX_A_P7_OMODE, 16'h0000, "om7");
    wr(`SUTX_A_MODE0, 16'h0011);
    rd(`SUTX_A_MODE0, 16'h0004, "mode0");
    b = $random(seed) & 8'h36;
    wr(`SUTX_A_P7_IBUF, {8'h00, b});
    rd(`SUTX_A_P7_IBUF, {8'h00, b}, "ibuf7");
    chk("ttl7", {8'h00, b}, {8'h00, ttl7});
    chk("ttl3", 16'h0000, {8'h00, ttl3});
    wr(`SUTX_A_PER_EN, 16'h0004);
    repeat (4) @(posedge clk_sys_in);
    wr(`SUTX_A_PRESC, 16'h0000);
    rd(`SUTX_A_OUT_LVL, 16'h0F0F, "level");
    rd(20'hF01FE, 16'h0000, "unmapped");
    wr(`SUTX_A_P7_LATCH, 16'h002D);
    wr(`SUTX_A_P3_LATCH, 16'h0005);
    wr(`SUTX_A_P7_DIR, 16'h00D2);
    wr(`SUTX_A_P3_DIR, 16'h00FA);
    wr(`SUTX_A_P7_OMODE, 16'h0008);
    repeat (3) @(posedge clk_sys_in);
    chk("od7", 16'h0008, {8'h00, p7_oe_n & 8'h08});
    wr(`SUTX_A_P7_OMODE, 16'h0000);
    repeat (3) @(posedge clk_sys_in);
    chk("pp7", 16'h0000, {8'h00, p7_oe_n & 8'h08});
    for (k = 0; k < 12; k = k + 1) begin
      ch = $unsigned($random(seed)) % 3;
      md = $random(seed) & 5'h1E;
      b = (k == 0) ? 8'h80 : $random(seed);
      dv = 7'h01 + k % 3;
      wr(`SUTX_A_MODE0 + {ch, 1'b0}, {11'h000, md});
      wr(`SUTX_A_STOP, 16'h0007);
      repeat (8) @(posedge clk_sys_in);
      wr(`SUTX_A_OUT_EN, 16'h0000);
      rd(`SUTX_A_CH_EN, 16'h0000, "chen");
      rd(`SUTX_A_STOP, 16'h0000, "stop");
      ckp <= {3{md[4]}};
      dap <= {3{md[3]}};
      wr(`SUTX_A_OUT_LVL, {4'h0, 1'b1, {3{~md[4]}}, 8'h0F});
      wr(`SUTX_A_OUT_EN, 16'h0007);
      wr(`SUTX_A_START, 16'h0007);
      wr(`SUTX_A_CH_EN, 16'h0000);
      rd(`SUTX_A_CH_EN, 16'h0007, "chen");
      wr(`SUTX_A_OUT_LVL, 16'h0000);
      rd(`SUTX_A_OUT_LVL, {4'h0, 1'b1, {3{~md[4]}}, 8'h0F}, "level");
      chk("pins", {10'h000, {3{~md[4]}}, 3'h7}, {10'h000, w3[2], w7[2], w7[5], w3[0], w7[0], w7[3]});
      clr <= 1'b1;
      @(posedge clk_sys_in);
      clr <= 1'b0;
      wr(`SUTX_A_DATA0 + {ch, 1'b0}, {dv, 1'b0, b});
      for (i = 0; i < 400 && irq[ch] !== 1'b1; i = i + 1) @(posedge clk_sys_in);
      limit(i < 400);
      repeat (3) @(posedge clk_sys_in);
      chk("count", md[2] ? 16'h0008 : 16'h0007, {8'h00, cnt[8*ch +: 8]});
      chk("bits", {8'h00, expect_bits(b, md[1], md[2])}, {8'h00, bits[8*ch +: 8]});
    end
    wr(`SUTX_A_MODE0, {11'h000, md | 5'h05});
    clr <= 1'b1;
    @(posedge clk_sys_in);
    clr <= 1'b0;
    for (k = 0; k < 17; k = k + 1) begin
      b = $random(seed);
      wr(`SUTX_A_DATA0, {7'h03, 1'b0, b});
    end
    chk("full", 16'h0000, {15'h0000, rdy[0]});
    for (i = 0; i < 3000 && cnt[7:0] !== 8'h88; i = i + 1) @(posedge clk_sys_in);
    limit(i < 3000);
    repeat (3) @(posedge clk_sys_in);
    chk("last", {8'h00, expect_bits(b, md[1], 1'b1)}, {8'h00, bits[7:0]});
    chk("drained", 16'h0001, {15'h0000, rdy[0]});
    end_of_test;
  end
endmodule // sutx_csi_tx_tb
